// *** inc/vfs_pkg.sv ***
package vfs_pkg;
  // timing in its own unit, counts derived from the 10 MHz clock
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned REC_WAIT_US     = 8_000;   // recovery after overvoltage
  localparam int unsigned START_WAIT_US   = 17_000;  // startup / undervoltage deglitch
  localparam int unsigned REC_WAIT_CYC    = REC_WAIT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned START_WAIT_CYC  = START_WAIT_US * (CLK_HZ / 1_000_000);
  // overvoltage integrator defaults
  localparam int unsigned OV_TRIP_LEVEL   = 110;     // integrator trip point
  localparam int unsigned OV_WEIGHT_W     = 4;       // excursion weight width
  localparam int unsigned TIMER_W         = 18;
  localparam int unsigned INTEG_W         = 12;
  // reset values
  localparam logic        GATE_RST        = 1'b0;
  localparam logic        GOOD_N_RST      = 1'b1;
  typedef enum logic [1:0] {VFS_IDLE, VFS_WAIT, VFS_ON} vfs_state_t;
  typedef enum logic {VFS_KIND_START, VFS_KIND_REC} vfs_kind_t;
endpackage

// *** core/vfs_sync.sv ***
`timescale 1ns/100ps
// two-flop synchroniser for a bank of level inputs
module vfs_sync #(
  parameter int unsigned W = 3
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // first stage feeds only the second
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

// *** core/vfs_sequencer.sv ***
`timescale 1ns/100ps
// How it works
// - over or undervoltage opens the power gate
// - any fault releases power_good_n high at once
// - overvoltage recovery closes gate after 8 ms
// - undervoltage or power-up closes after 17 ms
// - power_good_n goes low when the delay ends
// - timers clear to zero while input outside window
// - timers set gate and open-drain status
// - 17 ms deglitch rejects noise before turn-on
// - overvoltage integrated: bigger excursions trip sooner
// - status low inside window, whatever enable_n
// - over-temperature opens gate, recovers when cool
// - any fault: gate off, status high
module vfs_sequencer #(
  parameter int unsigned REC_CYC   = vfs_pkg::REC_WAIT_CYC,
  parameter int unsigned START_CYC = vfs_pkg::START_WAIT_CYC,
  parameter int unsigned OV_TRIP   = vfs_pkg::OV_TRIP_LEVEL
) (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst_n,
  // detector inputs
  input  wire logic                          undervoltage_flag,
  input  wire logic                          overvoltage_flag,
  input  wire logic                          overtemp_flag,
  input  wire logic [vfs_pkg::OV_WEIGHT_W-1:0] overvoltage_excess,
  // host enable, active low
  input  wire logic                          enable_n,
  // switch control
  output logic                               power_gate,
  output logic                               gate_pump,
  // open-drain status: line low when oe is high
  output logic                               power_good_n_o,
  output logic                               power_good_n_oe
);
  localparam int unsigned TW = vfs_pkg::TIMER_W;
  localparam int unsigned IW = vfs_pkg::INTEG_W;

  // =========================================================
  // input synchronisation
  logic [2:0] flags_s;
  logic [vfs_pkg::OV_WEIGHT_W-1:0] excess_m_q, excess_m_d, excess_q, excess_d;

  vfs_sync #(.W(3)) u_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .async_in ({overtemp_flag, overvoltage_flag, undervoltage_flag}),
    .sync_out (flags_s)
  );

  logic uv_s, ovraw_s, ot_s;
  assign uv_s    = flags_s[0];
  assign ovraw_s = flags_s[1];
  assign ot_s    = flags_s[2];

  // excursion weight crosses with two flops; small glitches only add a little
  always_comb begin
    excess_m_d = overvoltage_excess;
    excess_d   = excess_m_q;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      excess_m_q <= '0;
      excess_q   <= '0;
    end else begin
      excess_m_q <= excess_m_d;
      excess_q   <= excess_d;
    end
  end

  // =========================================================
  // overvoltage integrator
  logic [IW-1:0] integ_q, integ_d;
  logic          ov_q, ov_d;

  function automatic logic [IW-1:0] sat_add(input logic [IW-1:0] a,
                                            input logic [IW-1:0] b);
    logic [IW:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = s[IW] ? '1 : s[IW-1:0];
  endfunction

  // weight is excursion+1, so larger excursions reach the trip point sooner
  always_comb begin
    integ_d = integ_q;
    ov_d    = ov_q;
    if (ovraw_s) begin
      integ_d = sat_add(integ_q, IW'(excess_q) + IW'(1));
      if (integ_q >= IW'(OV_TRIP)) begin
        ov_d = 1'b1;
      end
    end else begin
      integ_d = '0; // raw flag low means below the hysteretic release level
      ov_d    = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      integ_q <= '0;
      ov_q    <= 1'b0;
    end else begin
      integ_q <= integ_d;
      ov_q    <= ov_d;
    end
  end

  // =========================================================
  // sequencer
  vfs_pkg::vfs_state_t state_q, state_d;
  vfs_pkg::vfs_kind_t  kind_q, kind_d;
  logic [TW-1:0]       timer_q, timer_d;
  logic                gate_q, gate_d;
  logic                pump_q, pump_d;
  logic                good_n_q, good_n_d;
  logic                window_bad, fault, run_osc;
  logic [TW-1:0]       target;

  assign window_bad = uv_s | ov_q;
  assign fault      = window_bad | ot_s;
  assign run_osc    = ~window_bad;
  assign target     = (kind_q == vfs_pkg::VFS_KIND_REC) ? TW'(REC_CYC - 1)
                                                       : TW'(START_CYC - 1);

  // fault takes priority over any running delay
  always_comb begin
    state_d  = state_q;
    kind_d   = kind_q;
    timer_d  = timer_q;
    gate_d   = 1'b0;
    pump_d   = 1'b0;
    good_n_d = fault;
    if (fault) begin
      state_d = vfs_pkg::VFS_IDLE;
      timer_d = '0;
      if (uv_s) begin
        kind_d = vfs_pkg::VFS_KIND_START;
      end else if (ov_q) begin
        kind_d = vfs_pkg::VFS_KIND_REC;
      end
    end else begin
      unique case (state_q)
        vfs_pkg::VFS_IDLE: begin
          state_d = vfs_pkg::VFS_WAIT;
          timer_d = '0;
        end
        vfs_pkg::VFS_WAIT: begin
          if (run_osc) begin
            if (timer_q >= target) begin
              state_d = vfs_pkg::VFS_ON;
              timer_d = '0;
            end else begin
              timer_d = timer_q + TW'(1);
            end
          end
        end
        vfs_pkg::VFS_ON: begin
          gate_d = ~enable_n;
          pump_d = ~enable_n;
        end
      endcase
      // status stays high until the delay finishes
      if (state_d != vfs_pkg::VFS_ON) begin
        good_n_d = 1'b1;
      end else begin
        good_n_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= vfs_pkg::VFS_IDLE;
      kind_q   <= vfs_pkg::VFS_KIND_START;
      timer_q  <= '0;
      gate_q   <= vfs_pkg::GATE_RST;
      pump_q   <= 1'b0;
      good_n_q <= vfs_pkg::GOOD_N_RST;
    end else begin
      state_q  <= state_d;
      kind_q   <= kind_d;
      timer_q  <= timer_d;
      gate_q   <= gate_d;
      pump_q   <= pump_d;
      good_n_q <= good_n_d;
    end
  end

  // =========================================================
  // outputs from flops, except power_good_n_o which is tied low
  assign power_gate      = gate_q;
  assign gate_pump       = pump_q;
  assign power_good_n_o  = 1'b0;
  assign power_good_n_oe = ~good_n_q;

  // =========================================================
  // check helper
  // counts cycles in the current wait apart from the design's timer,
  // so a skipped or doubled step of that timer shows in the checks
  logic [TW-1:0] wait_len_q, wait_len_d;

  always_comb begin
    wait_len_d = '0;
    if (state_q == vfs_pkg::VFS_WAIT) begin
      if (wait_len_q == '1) begin
        wait_len_d = wait_len_q; // hold at full scale, never wrap
      end else begin
        wait_len_d = wait_len_q + TW'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_len_q <= '0;
    end else begin
      wait_len_q <= wait_len_d;
    end
  end

  // =========================================================
  // checks
  property p_fault_opens;
    @(posedge clk_sys) disable iff (!rst_n) fault |=> !power_gate;
  endproperty
  a_fault_opens: assert property (p_fault_opens) else $error("gate on after fault");

  property p_fault_status;
    @(posedge clk_sys) disable iff (!rst_n) fault |=> !power_good_n_oe;
  endproperty
  a_fault_status: assert property (p_fault_status) else $error("status low in fault");

  property p_rec_wait;
    @(posedge clk_sys) disable iff (!rst_n)
      (state_q == vfs_pkg::VFS_WAIT && timer_q == '0 && kind_q == vfs_pkg::VFS_KIND_REC)
      |-> !(power_good_n_oe) [*8];
  endproperty
  a_rec_wait: assert property (p_rec_wait) else $error("early recovery");

  property p_timer_bound;
    @(posedge clk_sys) disable iff (!rst_n) timer_q <= TW'(START_CYC - 1);
  endproperty
  a_timer_bound: assert property (p_timer_bound) else $error("timer overrun");

  property p_good_with_on;
    @(posedge clk_sys) disable iff (!rst_n) power_gate |-> power_good_n_oe;
  endproperty
  a_good_with_on: assert property (p_good_with_on) else $error("gate on, status high");

  property p_halt;
    @(posedge clk_sys) disable iff (!rst_n) window_bad |=> timer_q == '0;
  endproperty
  a_halt: assert property (p_halt) else $error("timer ran in fault");

  property p_enable;
    @(posedge clk_sys) disable iff (!rst_n)
      (state_q == vfs_pkg::VFS_ON && !fault) |=> power_gate == !$past(enable_n);
  endproperty
  a_enable: assert property (p_enable) else $error("gate not following enable");

  property p_clear;
    @(posedge clk_sys) disable iff (!rst_n) fault |=> state_q == vfs_pkg::VFS_IDLE;
  endproperty
  a_clear: assert property (p_clear) else $error("delay not cleared");

  property p_pump_off;
    @(posedge clk_sys) disable iff (!rst_n) window_bad |=> !gate_pump;
  endproperty
  a_pump_off: assert property (p_pump_off) else $error("pump on outside window");

  property p_start_wait;
    @(posedge clk_sys) disable iff (!rst_n)
      (state_q == vfs_pkg::VFS_WAIT && timer_q == '0 && kind_q == vfs_pkg::VFS_KIND_START)
      |-> !(power_good_n_oe) [*8];
  endproperty
  a_start_wait: assert property (p_start_wait) else $error("early turn-on");

  property p_delay_len;
    @(posedge clk_sys) disable iff (!rst_n)
      (state_q == vfs_pkg::VFS_WAIT && state_d == vfs_pkg::VFS_ON)
      |-> wait_len_q == ((kind_q == vfs_pkg::VFS_KIND_REC) ? TW'(REC_CYC - 1)
                                                           : TW'(START_CYC - 1));
  endproperty
  a_delay_len: assert property (p_delay_len) else $error("wrong delay length");

  property p_ov_trip;
    @(posedge clk_sys) disable iff (!rst_n) (ovraw_s && integ_q >= IW'(OV_TRIP)) |=> ov_q;
  endproperty
  a_ov_trip: assert property (p_ov_trip) else $error("overvoltage not tripped");

  property p_ov_release;
    @(posedge clk_sys) disable iff (!rst_n) !ovraw_s |=> (!ov_q && integ_q == '0);
  endproperty
  a_ov_release: assert property (p_ov_release) else $error("integrator not cleared");

  property p_good_window;
    @(posedge clk_sys) disable iff (!rst_n)
      (state_q == vfs_pkg::VFS_ON && !fault) |=> power_good_n_oe;
  endproperty
  a_good_window: assert property (p_good_window) else $error("status high in window");

  property p_ot_off;
    @(posedge clk_sys) disable iff (!rst_n) ot_s |=> (!power_gate && !power_good_n_oe);
  endproperty
  a_ot_off: assert property (p_ot_off) else $error("gate on in overtemp");

  // main scenarios: turn-on, trips, restart in mid-count, host holding off
  c_turn_on:  cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(power_gate));
  c_ov_trip:  cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(ov_q));
  c_ot_event: cover property (@(posedge clk_sys) disable iff (!rst_n) ot_s && !window_bad);
  c_restart:  cover property (@(posedge clk_sys) disable iff (!rst_n)
                              state_q == vfs_pkg::VFS_WAIT && fault);
  c_hold_off: cover property (@(posedge clk_sys) disable iff (!rst_n)
                              state_q == vfs_pkg::VFS_ON && enable_n && !fault);
endmodule

// *** sim/vfs_host_model.sv ***
`timescale 1ns/100ps
// =====================================================================
// host side: drives enable and reads the open-drain status line
module vfs_host_model (
  // clock
  input  wire logic clk_sys,
  // bench request, high to let the switch close
  input  wire logic allow,
  // status line from the device
  input  wire logic power_good_n_o,
  input  wire logic power_good_n_oe,
  // host pins
  output logic      enable_n,
  output logic      status_n
);
  // enable follows the bench request, which moves on the falling edge;
  // no second falling-edge process, so no race with the bench
  assign enable_n = ~allow;
  // pull-up holds the line high whenever the device lets go of it
  assign status_n = power_good_n_oe ? power_good_n_o : 1'b1;
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/100ps
module testbench;
  // =====================================================================
  // stimulus, short counts so the run stays brief
  localparam int REC   = 8;
  localparam int START = 17;
  localparam int TRIP  = 4;
  logic       clk_sys = 1'b0;
  logic       rst_n   = 1'b0;
  logic       uv      = 1'b0;
  logic       ov      = 1'b0;
  logic       ot      = 1'b0;
  logic       allow   = 1'b1;
  logic [3:0] excess  = 4'h0;
  logic       enable_n, power_gate, gate_pump, pg_o, pg_oe, status_n;
  int         n_fail = 0;
  int         check_count = 0;
  int         cyc = 0;
  int         n, t_fast, t_slow;

  initial forever #50 clk_sys = ~clk_sys;

  // =====================================================================
  // device and host
  vfs_sequencer #(.REC_CYC(REC), .START_CYC(START), .OV_TRIP(TRIP)) vfs_sequencer_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .undervoltage_flag(uv), .overvoltage_flag(ov),
    .overtemp_flag(ot), .overvoltage_excess(excess), .enable_n(enable_n),
    .power_gate(power_gate), .gate_pump(gate_pump),
    .power_good_n_o(pg_o), .power_good_n_oe(pg_oe));
  vfs_host_model vfs_host_model_inst (
    .clk_sys(clk_sys), .allow(allow), .power_good_n_o(pg_o),
    .power_good_n_oe(pg_oe), .enable_n(enable_n), .status_n(status_n));

  // =====================================================================
  // checking and closing
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // counts falling edges until status reaches a level, bounded
  task automatic wait_status(input logic want, input int lim, output int cnt);
    cnt = 0;
    while (status_n !== want && cnt < lim) begin
      @(negedge clk_sys);
      cnt++;
    end
  endtask
  // watchdog: a hang counts as a mismatch
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      end_sim();
    end
  end

  // =====================================================================
  // scenarios
  initial begin
    repeat (8) @(negedge clk_sys);
    chk("gate in reset", power_gate, 1'b0);
    chk("status in reset", status_n, 1'b1);
    rst_n = 1'b1;
    wait_status(1'b0, 60, n);
    chk("startup delay", 8'(n >= START + 1 && n <= START + 6), 8'h01);
    repeat (3) @(negedge clk_sys);
    chk("gate on", power_gate, 1'b1);
    chk("pump with gate on", gate_pump, 1'b1);
    // host forces the switch open, status must not care
    allow = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk("gate with enable high", power_gate, 1'b0);
    chk("status with enable high", status_n, 1'b0);
    chk("pump with enable high", gate_pump, 1'b0);
    allow = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("gate re-enabled", power_gate, 1'b1);
    // undervoltage, then a glitch in mid-count must restart the delay
    uv = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("gate on undervoltage", power_gate, 1'b0);
    chk("status on undervoltage", status_n, 1'b1);
    chk("pump on undervoltage", gate_pump, 1'b0);
    uv = 1'b0;
    repeat (10) @(negedge clk_sys);
    uv = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("gate on glitch", power_gate, 1'b0);
    uv = 1'b0;
    wait_status(1'b0, 60, n);
    chk("restarted delay", 8'(n >= START + 1 && n <= START + 6), 8'h01);
    repeat (2) @(negedge clk_sys);
    chk("gate after recovery", power_gate, 1'b1);
    // overvoltage: slow excursion first, then a large one
    for (int i = 0; i < 2; i++) begin
      excess = i ? 4'hf : 4'h0;
      ov = 1'b1;
      wait_status(1'b1, 40, n);
      if (i) t_fast = n;
      else t_slow = n;
      chk("gate on overvoltage", power_gate, 1'b0);
      ov = 1'b0;
      wait_status(1'b0, 60, n);
      chk("overvoltage recovery", 8'(n >= REC + 1 && n <= REC + 6), 8'h01);
      repeat (3) @(negedge clk_sys);
    end
    chk("large excursion trips sooner", 8'(t_fast < t_slow), 8'h01);
    // over-temperature keeps the last recovery kind
    ot = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("gate on overtemp", power_gate, 1'b0);
    chk("status on overtemp", status_n, 1'b1);
    ot = 1'b0;
    wait_status(1'b0, 60, n);
    chk("overtemp recovery", 8'(n >= REC + 1 && n <= REC + 6), 8'h01);
    repeat (3) @(negedge clk_sys);
    chk("gate after overtemp", power_gate, 1'b1);
    end_sim();
  end
endmodule
